//--- logic/lecc_defs.svh
// register offsets, field positions and reset values of the link error / control channel / equalizer bank
`ifndef LECC_DEFS_SVH
`define LECC_DEFS_SVH

`define LECC_ADDR_LINK_ERR 8'h41
`define LECC_ADDR_FAST_CC 8'h43
`define LECC_ADDR_EQ_OVR 8'h44
`define LECC_ADDR_EQ_RANGE 8'h45
`define LECC_ADDR_IRQ_STATUS 8'h4c
`define LECC_ADDR_IRQ_MASK 8'h4d
`define LECC_ADDR_AUX 8'h4e

`define LECC_ERR_EN_BIT 4
`define LECC_ERR_THR_MSB 3
`define LECC_ERR_THR_LSB 0
`define LECC_MISO_MODE_BIT 4
`define LECC_CPOL_BIT 3
`define LECC_BCM_MSB 2
`define LECC_BCM_LSB 0
`define LECC_EQ_COARSE_MSB 7
`define LECC_EQ_COARSE_LSB 5
`define LECC_EQ_FINE_MSB 3
`define LECC_EQ_FINE_LSB 1
`define LECC_EQ_BYPASS_BIT 0
`define LECC_FLOOR_MSB 3
`define LECC_FLOOR_LSB 0
`define LECC_AUX_PORT1_BIT 0
`define LECC_AUX_FLOOR_EN_BIT 1
`define LECC_IRQ_LOST_BIT 0
`define LECC_IRQ_ACQ_BIT 1
`define LECC_IRQ_ERR_BIT 2

`define LECC_RST_LINK_ERR 8'h03
`define LECC_RST_FAST_CC 8'h00
`define LECC_RST_EQ_OVR 8'h60
`define LECC_RST_EQ_RANGE 8'h80
`define LECC_RST_AUX 8'h00
`define LECC_RST_IRQ 8'h00

`endif

//--- logic/lecc_pkg.sv
// types shared by the link error / control channel / equalizer register bank
`default_nettype none
package lecc_pkg;
   typedef enum logic [2:0] {
      LECC_BCM_NORMAL_GPIO = 3'h0,
      LECC_BCM_HS_GPIO1 = 3'h1,
      LECC_BCM_HS_GPIO2 = 3'h2,
      LECC_BCM_HS_GPIO4 = 3'h3,
      LECC_BCM_RSVD4 = 3'h4,
      LECC_BCM_RSVD5 = 3'h5,
      LECC_BCM_FWD_SPI = 3'h6,
      LECC_BCM_REV_SPI = 3'h7
   } lecc_bcm_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } lecc_reg_req_t;

   typedef struct packed {
      logic lane_zero_clock;
      logic lane_one_clock;
      logic control_align_stream;
   } lecc_lane_err_t;

   typedef struct packed {
      logic auto_equalizer_off;
      logic [5:0] equalizer_manual;
      logic [3:0] equalizer_start_floor;
   } lecc_eq_ctl_t;
endpackage
`default_nettype wire

//--- logic/lecc_err_counter.sv
// saturating link error counter with synchronous clear
`default_nettype none
module lecc_err_counter
   import lecc_pkg::*;
#(
   parameter int W = 4
)
(
   input wire logic sys_clk_i,
   input wire logic arst_n_i,
   input wire logic clk_en_i,
   input wire logic clear_i,
   input wire logic inc_i,
   output logic [W-1:0] count_o
);
   logic [W-1:0] next_count;

   // clear has priority so a new lock period starts at zero
   always_comb
   begin
      next_count = count_o;
      if (clear_i)
      begin
         next_count = '0;
      end
      else if (inc_i && (count_o != {W{1'b1}}))
      begin
         next_count = count_o + {{(W-1){1'b0}}, 1'b1};
      end
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         count_o <= '0;
      end
      else if (clk_en_i)
      begin
         count_o <= next_count;
      end
   end
endmodule
`default_nettype wire

//--- logic/lecc_regs.sv
// link error lock monitor, back-channel control and equalizer register bank
//
// Overview of operation
// - link errors are counted only while the count enable bit is one.
// - counting enabled, lock drops when the error count reaches the 4-bit threshold.
// - counting disabled, lock drops on the first link error.
// - counter runs on pixel clock, watching both clock lanes and the alignment stream.
// - reverse SPI: mode bit 0 always drives slave output; 1 tri-states when unselected.
// - polarity 0 drives on falling, samples rising; polarity 1 the opposite.
// - 3-bit mode field selects GPIO, high-speed GPIO, forward or reverse SPI.
// - bypass bit one turns adaptive equalization off; zero leaves it on.
// - when bypassed, setting is coarse field bits 7:5 and fine field bits 3:1.
// - second-port select redirects equalizer register accesses to port one.
// - floor enabled by strap or register, adaptation starts from the floor value.
//
// The plain strobed port is this design's own decision.
`include "lecc_defs.svh"
`default_nettype none
module lecc_regs
   import lecc_pkg::*;
#(
   parameter int NPORT = 2,
   parameter int THR_W = 4
)
(
   input wire logic sys_clk_i,
   input wire logic arst_n_i,
   input wire logic clk_en_i,
   input wire lecc_reg_req_t reg_req_i,
   output logic [7:0] reg_rdata_o,
   input wire lecc_lane_err_t lane_err_i,
   input wire logic lock_detect_i,
   input wire logic floor_strap_i,
   input wire logic spi_sclk_i,
   input wire logic spi_ss_n_i,
   input wire logic spi_miso_data_i,
   output logic link_lock_o,
   output lecc_bcm_t back_channel_mode_o,
   output logic serial_clock_polarity_o,
   output logic spi_miso_o,
   output logic spi_miso_oe_o,
   output logic spi_sample_o,
   output lecc_eq_ctl_t [NPORT-1:0] eq_ctl_o,
   output logic eq_floor_en_o,
   output logic irq_o
);
   typedef enum logic [1:0] {LECC_ST_UNLOCKED, LECC_ST_LOCKED, LECC_ST_DROPPED} lecc_lock_st_t;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers: bit 0 floor strap, bit 1 sclk, bit 2 slave select
   logic [2:0] pin_raw;
   logic [2:0] sync1;
   logic [2:0] sync2;
   logic sclk_q;
   assign pin_raw = {spi_ss_n_i, spi_sclk_i, floor_strap_i};

   for (genvar b = 0; b < 3; b++)
   begin : g_sync
      always_ff @(posedge sys_clk_i or negedge arst_n_i)
      begin
         if (!arst_n_i)
         begin
            sync1[b] <= (b == 2);
            sync2[b] <= (b == 2);
         end
         else if (clk_en_i)
         begin
            sync1[b] <= pin_raw[b];
            sync2[b] <= sync1[b];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register file
   logic [7:0] link_error_monitor_ctl;
   logic [7:0] fast_control_channel_ctl;
   logic [7:0] equalizer_manual_override [NPORT];
   logic [7:0] equalizer_range_config [NPORT];
   logic [7:0] aux_ctl;
   logic [7:0] irq_status;
   logic [7:0] irq_mask;
   logic [7:0] next_link_error_monitor_ctl;
   logic [7:0] next_fast_control_channel_ctl;
   logic [7:0] next_aux_ctl;
   logic [7:0] next_irq_status;
   logic [7:0] next_irq_mask;
   logic [7:0] next_rdata;
   logic [7:0] irq_events;
   logic wr_hit_eq_ovr;
   logic wr_hit_eq_rng;
   int unsigned port_idx;

   logic err_en;
   logic [THR_W-1:0] err_thr;
   logic second_port_select;
   assign err_en = link_error_monitor_ctl[`LECC_ERR_EN_BIT];
   assign err_thr = link_error_monitor_ctl[`LECC_ERR_THR_MSB:`LECC_ERR_THR_LSB];
   assign second_port_select = aux_ctl[`LECC_AUX_PORT1_BIT];
   assign port_idx = second_port_select ? 1 : 0;
   assign wr_hit_eq_ovr = reg_req_i.wr && (reg_req_i.addr == `LECC_ADDR_EQ_OVR);
   assign wr_hit_eq_rng = reg_req_i.wr && (reg_req_i.addr == `LECC_ADDR_EQ_RANGE);

   always_comb
   begin
      next_link_error_monitor_ctl = link_error_monitor_ctl;
      next_fast_control_channel_ctl = fast_control_channel_ctl;
      next_aux_ctl = aux_ctl;
      next_irq_mask = irq_mask;
      // a new event wins over a write-one clear in the same cycle
      next_irq_status = irq_status | irq_events;
      next_rdata = 8'h00;
      if (reg_req_i.wr)
      begin
         unique case (reg_req_i.addr)
            `LECC_ADDR_LINK_ERR: next_link_error_monitor_ctl = reg_req_i.wdata;
            `LECC_ADDR_FAST_CC: next_fast_control_channel_ctl = reg_req_i.wdata;
            `LECC_ADDR_AUX: next_aux_ctl = reg_req_i.wdata;
            `LECC_ADDR_IRQ_MASK: next_irq_mask = reg_req_i.wdata;
            `LECC_ADDR_IRQ_STATUS: next_irq_status = (irq_status & ~reg_req_i.wdata) | irq_events;
            default: ;
         endcase
      end
      if (reg_req_i.rd)
      begin
         unique case (reg_req_i.addr)
            `LECC_ADDR_LINK_ERR: next_rdata = link_error_monitor_ctl;
            `LECC_ADDR_FAST_CC: next_rdata = fast_control_channel_ctl;
            `LECC_ADDR_EQ_OVR: next_rdata = equalizer_manual_override[port_idx];
            `LECC_ADDR_EQ_RANGE: next_rdata = equalizer_range_config[port_idx];
            `LECC_ADDR_AUX: next_rdata = aux_ctl;
            `LECC_ADDR_IRQ_STATUS: next_rdata = irq_status;
            `LECC_ADDR_IRQ_MASK: next_rdata = irq_mask;
            default: next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         link_error_monitor_ctl <= `LECC_RST_LINK_ERR;
         fast_control_channel_ctl <= `LECC_RST_FAST_CC;
         aux_ctl <= `LECC_RST_AUX;
         irq_status <= `LECC_RST_IRQ;
         irq_mask <= `LECC_RST_IRQ;
         reg_rdata_o <= 8'h00;
         irq_o <= 1'b0;
      end
      else if (clk_en_i)
      begin
         link_error_monitor_ctl <= next_link_error_monitor_ctl;
         fast_control_channel_ctl <= next_fast_control_channel_ctl;
         aux_ctl <= next_aux_ctl;
         irq_status <= next_irq_status;
         irq_mask <= next_irq_mask;
         reg_rdata_o <= next_rdata;
         irq_o <= |(next_irq_status & next_irq_mask);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // per-port equalizer banks, only the selected port takes a write
   for (genvar p = 0; p < NPORT; p++)
   begin : g_eq
      logic [7:0] next_ovr;
      logic [7:0] next_rng;
      always_comb
      begin
         next_ovr = equalizer_manual_override[p];
         next_rng = equalizer_range_config[p];
         if (wr_hit_eq_ovr && (port_idx == p))
         begin
            next_ovr = reg_req_i.wdata;
         end
         if (wr_hit_eq_rng && (port_idx == p))
         begin
            next_rng = reg_req_i.wdata;
         end
      end
      always_ff @(posedge sys_clk_i or negedge arst_n_i)
      begin
         if (!arst_n_i)
         begin
            equalizer_manual_override[p] <= `LECC_RST_EQ_OVR;
            equalizer_range_config[p] <= `LECC_RST_EQ_RANGE;
         end
         else if (clk_en_i)
         begin
            equalizer_manual_override[p] <= next_ovr;
            equalizer_range_config[p] <= next_rng;
         end
      end
      // equalizer core ignores the manual value unless bypassed
      assign eq_ctl_o[p].auto_equalizer_off = equalizer_manual_override[p][`LECC_EQ_BYPASS_BIT];
      assign eq_ctl_o[p].equalizer_manual = {equalizer_manual_override[p][`LECC_EQ_COARSE_MSB:`LECC_EQ_COARSE_LSB],
                                             equalizer_manual_override[p][`LECC_EQ_FINE_MSB:`LECC_EQ_FINE_LSB]};
      assign eq_ctl_o[p].equalizer_start_floor = equalizer_range_config[p][`LECC_FLOOR_MSB:`LECC_FLOOR_LSB];
   end

   ////////////////////////////////////////////////////////////////////////////
   // lock monitor and error counter
   lecc_lock_st_t lock_st;
   lecc_lock_st_t next_lock_st;
   logic [THR_W-1:0] err_count;
   logic err_any;
   logic drop;
   logic cnt_clear;
   logic cnt_inc;

   assign err_any = |lane_err_i;

   always_comb
   begin
      drop = 1'b0;
      next_lock_st = lock_st;
      unique case (lock_st)
         LECC_ST_UNLOCKED:
         begin
            if (lock_detect_i)
            begin
               next_lock_st = LECC_ST_LOCKED;
            end
         end
         LECC_ST_LOCKED:
         begin
            // reaching threshold counts the error of this cycle
            drop = err_any && (!err_en || ({1'b0, err_count} + 5'h01 >= {1'b0, err_thr}));
            if (!lock_detect_i)
            begin
               next_lock_st = LECC_ST_UNLOCKED;
            end
            else if (drop)
            begin
               next_lock_st = LECC_ST_DROPPED;
            end
         end
         LECC_ST_DROPPED:
         begin
            // relock only after the recovery logic itself lets go
            if (!lock_detect_i)
            begin
               next_lock_st = LECC_ST_UNLOCKED;
            end
         end
      endcase
      cnt_clear = (lock_st == LECC_ST_LOCKED) != (next_lock_st == LECC_ST_LOCKED);
      cnt_inc = err_en && err_any && (lock_st == LECC_ST_LOCKED);
      irq_events = 8'h00;
      irq_events[`LECC_IRQ_LOST_BIT] = (lock_st == LECC_ST_LOCKED) && (next_lock_st != LECC_ST_LOCKED);
      irq_events[`LECC_IRQ_ACQ_BIT] = (lock_st != LECC_ST_LOCKED) && (next_lock_st == LECC_ST_LOCKED);
      irq_events[`LECC_IRQ_ERR_BIT] = err_any && (lock_st == LECC_ST_LOCKED);
   end

   lecc_err_counter #(.W(THR_W)) u_err_counter (
      .sys_clk_i(sys_clk_i),
      .arst_n_i(arst_n_i),
      .clk_en_i(clk_en_i),
      .clear_i(cnt_clear),
      .inc_i(cnt_inc),
      .count_o(err_count)
   );

   ////////////////////////////////////////////////////////////////////////////
   // back channel mode, spi pin and floor enable outputs
   logic rev_spi;
   logic spi_mode;
   logic sclk_rise;
   logic sclk_fall;
   logic next_miso;
   logic next_miso_oe;
   logic next_sample;
   assign rev_spi = fast_control_channel_ctl[`LECC_BCM_MSB:`LECC_BCM_LSB] == LECC_BCM_REV_SPI;
   assign spi_mode = fast_control_channel_ctl[`LECC_BCM_MSB:`LECC_BCM_LSB] == LECC_BCM_FWD_SPI || rev_spi;
   assign sclk_rise = sync2[1] && !sclk_q;
   assign sclk_fall = !sync2[1] && sclk_q;

   always_comb
   begin
      next_miso = spi_miso_o;
      if (rev_spi && (fast_control_channel_ctl[`LECC_CPOL_BIT] ? sclk_rise : sclk_fall))
      begin
         next_miso = spi_miso_data_i;
      end
      next_sample = spi_mode && (fast_control_channel_ctl[`LECC_CPOL_BIT] ? sclk_fall : sclk_rise);
      // bused slaves must release the line when not selected
      next_miso_oe = rev_spi && (!fast_control_channel_ctl[`LECC_MISO_MODE_BIT] || !sync2[2]);
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         lock_st <= LECC_ST_UNLOCKED;
         link_lock_o <= 1'b0;
         sclk_q <= 1'b0;
         spi_miso_o <= 1'b0;
         spi_miso_oe_o <= 1'b0;
         spi_sample_o <= 1'b0;
         back_channel_mode_o <= LECC_BCM_NORMAL_GPIO;
         serial_clock_polarity_o <= 1'b0;
         eq_floor_en_o <= 1'b0;
      end
      else if (clk_en_i)
      begin
         lock_st <= next_lock_st;
         link_lock_o <= next_lock_st == LECC_ST_LOCKED;
         sclk_q <= sync2[1];
         spi_miso_o <= next_miso;
         spi_miso_oe_o <= next_miso_oe;
         spi_sample_o <= next_sample;
         back_channel_mode_o <= lecc_bcm_t'(fast_control_channel_ctl[`LECC_BCM_MSB:`LECC_BCM_LSB]);
         serial_clock_polarity_o <= fast_control_channel_ctl[`LECC_CPOL_BIT];
         eq_floor_en_o <= sync2[0] || aux_ctl[`LECC_AUX_FLOOR_EN_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!arst_n_i);

   sequence s_locked_err;
      clk_en_i && (lock_st == LECC_ST_LOCKED) && lock_detect_i && err_any;
   endsequence

   property p_no_count_when_off;
      clk_en_i && !err_en && !cnt_clear |=> $stable(err_count);
   endproperty
   a_no_count_when_off: assert property (p_no_count_when_off) else $error("error count moved while disabled");

   property p_drop_at_thr;
      s_locked_err and (err_en && ({1'b0, err_count} + 5'h01 >= {1'b0, err_thr})) |=> !link_lock_o;
   endproperty
   a_drop_at_thr: assert property (p_drop_at_thr) else $error("lock kept at threshold");

   property p_drop_first_err;
      s_locked_err and !err_en |=> !link_lock_o ##1 !link_lock_o;
   endproperty
   a_drop_first_err: assert property (p_drop_first_err) else $error("lock kept after error with count off");

   property p_count_step;
      s_locked_err and (err_en && ({1'b0, err_count} + 5'h01 < {1'b0, err_thr}))
         |=> (err_count == $past(err_count) + 4'h1) && link_lock_o;
   endproperty
   a_count_step: assert property (p_count_step) else $error("lane error not counted");

   property p_miso_oe;
      clk_en_i && rev_spi && !fast_control_channel_ctl[`LECC_MISO_MODE_BIT] |=> spi_miso_oe_o;
   endproperty
   a_miso_oe: assert property (p_miso_oe) else $error("slave output released in always-drive mode");

   property p_miso_tristate;
      clk_en_i && fast_control_channel_ctl[`LECC_MISO_MODE_BIT] && sync2[2] |=> !spi_miso_oe_o;
   endproperty
   a_miso_tristate: assert property (p_miso_tristate) else $error("slave output driven while unselected");

   property p_drive_edge;
      clk_en_i && rev_spi && fast_control_channel_ctl[`LECC_CPOL_BIT] && sclk_rise
         |=> spi_miso_o == $past(spi_miso_data_i);
   endproperty
   a_drive_edge: assert property (p_drive_edge) else $error("data not driven on rising edge");

   sequence s_write_fwd_spi;
      clk_en_i && reg_req_i.wr && (reg_req_i.addr == `LECC_ADDR_FAST_CC) && (reg_req_i.wdata[2:0] == 3'h6);
   endsequence

   property p_mode_fwd_spi;
      s_write_fwd_spi ##1 clk_en_i |=> back_channel_mode_o == LECC_BCM_FWD_SPI;
   endproperty
   a_mode_fwd_spi: assert property (p_mode_fwd_spi) else $error("mode not forward spi");

   property p_eq_manual;
      clk_en_i && wr_hit_eq_ovr && !second_port_select
         |=> eq_ctl_o[0].equalizer_manual == {$past(reg_req_i.wdata[7:5]), $past(reg_req_i.wdata[3:1])}
             && eq_ctl_o[0].auto_equalizer_off == $past(reg_req_i.wdata[0]);
   endproperty
   a_eq_manual: assert property (p_eq_manual) else $error("port zero equalizer setting wrong");

   property p_port1_redirect;
      clk_en_i && wr_hit_eq_ovr && second_port_select
         |=> $stable(eq_ctl_o[0]) && eq_ctl_o[1].auto_equalizer_off == $past(reg_req_i.wdata[0]);
   endproperty
   a_port1_redirect: assert property (p_port1_redirect) else $error("port one write not redirected");

   property p_clear_on_loss;
      clk_en_i && (lock_st == LECC_ST_LOCKED) && !lock_detect_i |=> err_count == 4'h0;
   endproperty
   a_clear_on_loss: assert property (p_clear_on_loss) else $error("counter not cleared on loss");
endmodule
`default_nettype wire

//--- verification/lecc_far_model.sv
// far-side model: forward link lock, lane error flags and spi master pins
`default_nettype none
module lecc_far_model
   import lecc_pkg::*;
(
   input wire logic sys_clk_i,
   output lecc_lane_err_t lane_err_o,
   output logic lock_detect_o,
   output logic spi_sclk_o,
   output logic spi_ss_n_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      lane_err_o = '0;
      lock_detect_o = 1'b0;
      spi_sclk_o = 1'b0;
      spi_ss_n_o = 1'b1;
   end
   // one error cycle per call, any lane mix
   task automatic err_pulse(input lecc_lane_err_t lanes);
      @(posedge sys_clk_i);
      lane_err_o <= lanes;
      @(posedge sys_clk_i);
      lane_err_o <= '0;
   endtask
   task automatic set_lock(input logic v);
      @(posedge sys_clk_i);
      lock_detect_o <= v;
   endtask
   task automatic select(input logic v);
      @(posedge sys_clk_i);
      spi_ss_n_o <= ~v;
   endtask
   // idle at polarity level, then sample edge and drive edge; slow for the pin synchronisers
   task automatic spi_bit(input logic pol);
      @(posedge sys_clk_i);
      spi_sclk_o <= pol;
      repeat (4) @(posedge sys_clk_i);
      spi_sclk_o <= ~pol;
      repeat (4) @(posedge sys_clk_i);
      spi_sclk_o <= pol;
   endtask
endmodule
`default_nettype wire

//--- verification/tb_top.sv
// self-checking bench of the link error / control channel / equalizer bank
`default_nettype none
module tb_top
   import lecc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk;
   logic arst_n;
   logic clk_en;
   logic strap;
   logic miso_d;
   lecc_reg_req_t req;
   lecc_lane_err_t lane_err;
   logic lock_det, sclk, ss_n, link_lock, cpol, miso, miso_oe, sample, floor_en, irq;
   logic [7:0] rdata;
   lecc_bcm_t bcm;
   lecc_eq_ctl_t [1:0] eq_ctl;
   logic [7:0] exp_q[$];
   logic rd_pend = 1'b0;
   int miscompares = 0;
   int num_checks = 0;
   int samples = 0;
   int n;
   logic [31:0] seed = 32'h79b6;
   logic [31:0] r;
   logic [7:0] v;
   logic [7:0] addrs [8] = '{8'h41, 8'h43, 8'h44, 8'h45, 8'h4c, 8'h4d, 8'h4e, 8'h50};
   logic [7:0] rsts [8] = '{8'h03, 8'h00, 8'h60, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00};

   always #5 sys_clk = ~sys_clk;

   lecc_regs lecc_regs_inst (.sys_clk_i(sys_clk), .arst_n_i(arst_n), .clk_en_i(clk_en), .reg_req_i(req),
      .reg_rdata_o(rdata), .lane_err_i(lane_err), .lock_detect_i(lock_det), .floor_strap_i(strap),
      .spi_sclk_i(sclk), .spi_ss_n_i(ss_n), .spi_miso_data_i(miso_d), .link_lock_o(link_lock),
      .back_channel_mode_o(bcm), .serial_clock_polarity_o(cpol), .spi_miso_o(miso), .spi_miso_oe_o(miso_oe),
      .spi_sample_o(sample), .eq_ctl_o(eq_ctl), .eq_floor_en_o(floor_en), .irq_o(irq));
   lecc_far_model lecc_far_model_inst (.sys_clk_i(sys_clk), .lane_err_o(lane_err), .lock_detect_o(lock_det),
      .spi_sclk_o(sclk), .spi_ss_n_o(ss_n));

   ////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic test_done();
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk);
      req <= '0;
   endtask
   // expectation noted here, compared by the read monitor
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      @(posedge sys_clk);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk);
      req <= '0;
   endtask

   ////////////////////////////////////////////////////////////////
   // read data stands only in the cycle after the strobe
   always @(negedge sys_clk)
   begin
      if (rd_pend)
         chk(rdata, exp_q.pop_front());
      rd_pend = req.rd;
   end
   // counted off the launching edge so the pulse is settled
   always @(negedge sys_clk)
      if (sample === 1'b1)
         samples++;

   initial
   begin
      sys_clk = 1'b0;
      arst_n = 1'b0;
      clk_en = 1'b1;
      strap = 1'b0;
      miso_d = 1'b0;
      req = '0;
      repeat (5) @(posedge sys_clk);
      arst_n <= 1'b1;
      for (int i = 0; i < 8; i++)
         rd(addrs[i], rsts[i]);
      chk(8'(eq_ctl[0].equalizer_manual), 8'h18);
      // every mode code, reserved ones included
      for (int m = 0; m < 8; m++)
      begin
         r = xs();
         v = {r[7:5], 2'b00, 3'(m)};
         wr(8'h43, v);
         cyc(2);
         chk(8'(bcm), 8'(m));
         chk(8'(miso_oe), 8'(m == 7));
         rd(8'h43, v);
      end
      // reverse spi: k[0] polarity, k[1] tri-state when unselected
      for (int k = 0; k < 4; k++)
      begin
         wr(8'h43, {3'h0, k[1], k[0], 3'h7});
         lecc_far_model_inst.select(1'b0);
         cyc(4);
         chk(8'(miso_oe), 8'(!k[1]));
         chk(8'(cpol), 8'(k[0]));
         lecc_far_model_inst.select(1'b1);
         r = xs();
         miso_d <= r[0];
         n = samples;
         lecc_far_model_inst.spi_bit(k[0]);
         cyc(5);
         chk(8'(miso_oe), 8'h01);
         chk(8'(miso), 8'(r[0]));
         chk(8'(samples - n), 8'h01);
      end
      // threshold 3 with counting on, errors spread over lanes
      wr(8'h4d, 8'h01);
      wr(8'h41, 8'h13);
      lecc_far_model_inst.set_lock(1'b1);
      cyc(2);
      chk(8'(link_lock), 8'h01);
      lecc_far_model_inst.err_pulse(3'b100);
      lecc_far_model_inst.err_pulse(3'b011);
      cyc(2);
      chk(8'(link_lock), 8'h01);
      chk(8'(irq), 8'h00);
      lecc_far_model_inst.err_pulse(3'b010);
      cyc(2);
      chk(8'(link_lock), 8'h00);
      chk(8'(irq), 8'h01);
      rd(8'h4c, 8'h07);
      wr(8'h4c, 8'h07);
      cyc(1);
      chk(8'(irq), 8'h00);
      rd(8'h4c, 8'h00);
      // relock starts from zero: two errors must not drop
      lecc_far_model_inst.set_lock(1'b0);
      lecc_far_model_inst.set_lock(1'b1);
      cyc(2);
      chk(8'(link_lock), 8'h01);
      lecc_far_model_inst.err_pulse(3'b001);
      lecc_far_model_inst.err_pulse(3'b001);
      cyc(2);
      chk(8'(link_lock), 8'h01);
      wr(8'h41, 8'h03);
      lecc_far_model_inst.err_pulse(3'b001);
      cyc(2);
      chk(8'(link_lock), 8'h00);
      // loss while locked clears the count: one error, loss, relock, two errors keep lock
      wr(8'h41, 8'h13);
      lecc_far_model_inst.set_lock(1'b0);
      lecc_far_model_inst.set_lock(1'b1);
      lecc_far_model_inst.err_pulse(3'b001);
      lecc_far_model_inst.set_lock(1'b0);
      lecc_far_model_inst.set_lock(1'b1);
      lecc_far_model_inst.err_pulse(3'b001);
      lecc_far_model_inst.err_pulse(3'b001);
      cyc(2);
      chk(8'(link_lock), 8'h01);
      // clock enable low: a write is dropped and lock state is frozen
      @(posedge sys_clk);
      clk_en <= 1'b0;
      wr(8'h4d, 8'hff);
      lecc_far_model_inst.set_lock(1'b0);
      cyc(2);
      chk(8'(link_lock), 8'h01);
      @(posedge sys_clk);
      clk_en <= 1'b1;
      rd(8'h4d, 8'h01);
      cyc(2);
      chk(8'(link_lock), 8'h00);
      // equalizer: port 0 manual, then port 1 through the select bit
      r = xs();
      v = {r[7:1], 1'b1};
      wr(8'h44, v);
      wr(8'h45, {4'h8, r[11:8]});
      cyc(1);
      chk(8'(eq_ctl[0].auto_equalizer_off), 8'h01);
      chk(8'(eq_ctl[0].equalizer_manual), 8'({v[7:5], v[3:1]}));
      chk(8'(eq_ctl[0].equalizer_start_floor), 8'(r[11:8]));
      chk(8'(eq_ctl[1].equalizer_manual), 8'h18);
      wr(8'h4e, 8'h01);
      rd(8'h44, 8'h60);
      wr(8'h44, 8'h00);
      cyc(1);
      chk(8'(eq_ctl[1].auto_equalizer_off), 8'h00);
      chk(8'(eq_ctl[1].equalizer_manual), 8'h00);
      chk(8'(eq_ctl[0].equalizer_manual), 8'({v[7:5], v[3:1]}));
      chk(8'(floor_en), 8'h00);
      wr(8'h4e, 8'h02);
      cyc(2);
      chk(8'(floor_en), 8'h01);
      wr(8'h4e, 8'h00);
      @(posedge sys_clk);
      strap <= 1'b1;
      cyc(5);
      chk(8'(floor_en), 8'h01);
      cyc(2);
      if (exp_q.size() != 0)
      begin
         miscompares++;
         $display("wrong value at %0t: reads left unanswered", $time);
      end
      test_done();
   end
endmodule
`default_nettype wire
